// ### vcc_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 20 MHz system clock, registers on a 32-bit Wishbone slave
// Notes: Byte address of a register is four times its index
`ifndef VCC_DEFS_SVH
`define VCC_DEFS_SVH

// Register indices (byte address = index * 4)
`define VCC_IDX_CLOCK_CODING 4'h0
`define VCC_IDX_INTERFACE 4'h1
`define VCC_IDX_RX_WORD 4'h2
`define VCC_IDX_TX_WORD 4'h3
`define VCC_IDX_ROUTING 4'h4
`define VCC_IDX_SIDETONE 4'h5
`define VCC_IDX_SPEAKER 4'h6
`define VCC_IDX_TONE_CTRL 4'h7
`define VCC_IDX_TONE_ONE 4'h8
`define VCC_IDX_TONE_TWO 4'h9
`define VCC_IDX_TEST_RANGE 4'hA
`define VCC_IDX_BUZZER 4'hB
`define VCC_IDX_TEST_MUX 4'hE
`define VCC_RST_VALUE 8'h00

// clock_coding_config fields
`define VCC_CLK_SEL_HI 7
`define VCC_CLK_SEL_LO 6
`define VCC_CODING_BIT 5
`define VCC_LAW_HI 4
`define VCC_LAW_LO 3
`define VCC_FRAME_FMT 2
`define VCC_SEVEN_BIT 1
`define VCC_DLOOP 0

// interface_control fields
`define VCC_TIM_DELAY 7
`define VCC_TIM_POL 6
`define VCC_LATCH 5
`define VCC_RX_HOST 4
`define VCC_TX_HOST 3
`define VCC_VOICE_EN 2
`define VCC_CHAN_SEL 1

// tone_control, test_range_control, buzzer_control fields
`define VCC_TONE1_EN 3
`define VCC_TONE2_EN 2
`define VCC_WAVE_SEL 1
`define VCC_POR_BIT 7
`define VCC_TXRX_LOOP 3
`define VCC_EXP_LOOP 2
`define VCC_RANGE_DBL 1
`define VCC_RANGE_HALF 0
`define VCC_BUZ_EN 7
`define VCC_BUZ_INV 6
`define VCC_DUTY_HI 5

// Timing and ratios
`define VCC_CLK_HZ 64'd20000000
`define VCC_GAP_BITS 2'd2
`define VCC_DIV_512K 3'd1
`define VCC_DIV_1536K 3'd3
`define VCC_DIV_2048K 3'd4
`define VCC_DIV_2560K 3'd5
// Tone unit period: f = code / period, period in microseconds
`define VCC_TONE_STD_US 64'd128000
`define VCC_TONE_HALF_US 64'd256000
`define VCC_TONE_DBL_US 64'd64000
`define VCC_TONE_STEP(us) ((64'd4294967296 * 64'd1000000) / ((us) * `VCC_CLK_HZ))
`endif

// ### vcc_pkg.sv
// Purpose: Shared types of the voice codec control block
// Assumes: Nothing beyond the defs header
// Notes: Constants live in vcc_defs.svh
package vcc_pkg;
    typedef logic [7:0] vcc_byte_t;
    typedef enum logic [1:0] {
        VCC_RANGE_STD = 2'h0,
        VCC_RANGE_HALF = 2'h1,
        VCC_RANGE_DOUBLE = 2'h2,
        VCC_RANGE_BAD = 2'h3
    } vcc_range_t;
    typedef enum logic [2:0] {
        VCC_TIM_DELAYED = 3'h1,
        VCC_TIM_NORMAL = 3'h2,
        VCC_TIM_REVERSED = 3'h4
    } vcc_timing_t;
endpackage

// ### vcc_tone_gen.sv
// Purpose: Two phase-accumulator tone sources, square or sine
// Assumes: Codes and range already aligned to a frame boundary
// Notes: Sine is a coarse 16-step table, enough for ring tones
`timescale 1ns/10ps
`include "vcc_defs.svh"
module vcc_tone_gen #(
    parameter int ACC_W = 32
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Control
    input wire logic tone1_on,
    input wire logic tone2_on,
    input wire logic sine_sel,
    input wire vcc_pkg::vcc_range_t range_sel,
    input wire vcc_pkg::vcc_byte_t freq1,
    input wire vcc_pkg::vcc_byte_t freq2,
    // Results
    output logic [8:0] sample,
    output logic sq2,
    output logic [6:0] phase1_hi
);
    import vcc_pkg::*;

    // Step constants are worked out for a 32-bit phase word only
    if (ACC_W != 32) begin : g_acc_check
        $error("vcc_tone_gen: steps assume a 32-bit accumulator");
    end

    logic [ACC_W-1:0] acc1_q;
    logic [ACC_W-1:0] acc2_q;
    logic [ACC_W-1:0] unit_step;
    logic [7:0] wave1;
    logic [7:0] wave2;

    function automatic logic [7:0] sine16(input logic [3:0] ph);
        logic [7:0] v;
        v = 8'h80;
        case (ph)
            4'h0: v = 8'h80;
            4'h1: v = 8'hB0;
            4'h2: v = 8'hDA;
            4'h3: v = 8'hF6;
            4'h4: v = 8'hFF;
            4'h5: v = 8'hF6;
            4'h6: v = 8'hDA;
            4'h7: v = 8'hB0;
            4'h8: v = 8'h80;
            4'h9: v = 8'h50;
            4'hA: v = 8'h26;
            4'hB: v = 8'h0A;
            4'hC: v = 8'h01;
            4'hD: v = 8'h0A;
            4'hE: v = 8'h26;
            default: v = 8'h50;
        endcase
        return v;
    endfunction

    // R18 range scaling
    assign unit_step = (range_sel == VCC_RANGE_HALF) ?
        ACC_W'(`VCC_TONE_STEP(`VCC_TONE_HALF_US)) :
        (range_sel == VCC_RANGE_DOUBLE) ?
        ACC_W'(`VCC_TONE_STEP(`VCC_TONE_DBL_US)) :
        ACC_W'(`VCC_TONE_STEP(`VCC_TONE_STD_US));

    always_ff @(posedge clk_sys) begin
        if (reset || !tone1_on) begin
            acc1_q <= '0;
        end else begin
            acc1_q <= acc1_q + ACC_W'(unit_step * ACC_W'(freq1));
        end
        if (reset || !tone2_on) begin
            acc2_q <= '0;
        end else begin
            acc2_q <= acc2_q + ACC_W'(unit_step * ACC_W'(freq2));
        end
    end

    // R17 waveform choice
    assign wave1 = sine_sel ? sine16(acc1_q[ACC_W-1 -: 4]) :
        {8{acc1_q[ACC_W-1]}};
    assign wave2 = sine_sel ? sine16(acc2_q[ACC_W-1 -: 4]) :
        {8{acc2_q[ACC_W-1]}};
    assign sq2 = acc2_q[ACC_W-1];
    assign phase1_hi = acc1_q[ACC_W-1 -: 7];

    // R16 tone mixing
    assign sample = (tone1_on && tone2_on && !sine_sel) ?
            (sq2 ? {1'b0, wave1} : 9'h000) :
        (tone1_on && tone2_on) ? ({1'b0, wave1} + {1'b0, wave2}) :
        tone1_on ? {1'b0, wave1} :
        tone2_on ? {1'b0, wave2} : 9'h000;
endmodule

// ### vcc_buzzer_pwm.sv
// Purpose: Buzzer pin driver, PWM of the first tone or a static level
// Assumes: phase_hi is the top 7 bits of the first tone phase
// Notes: Duty step is one part in 128 of the tone period
`timescale 1ns/10ps
module vcc_buzzer_pwm (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Control
    input wire logic buzz_en,
    input wire logic buzz_inv,
    input wire logic [5:0] duty,
    input wire logic am_on,
    // Tone phase
    input wire logic [6:0] phase_hi,
    input wire logic mod_level,
    // Pin
    output logic buzzer_pin
);
    logic pulse;
    logic shaped;
    logic buzz_d;

    // R22 duty from field
    assign pulse = {1'b0, duty} > phase_hi;
    assign shaped = buzz_inv ? pulse : ~pulse;
    // R21 enable, AM or static level
    assign buzz_d = !buzz_en ? ~buzz_inv :
        (am_on && !mod_level) ? 1'b0 : shaped;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            buzzer_pin <= 1'b1;
        end else begin
            buzzer_pin <= buzz_d;
        end
    end
endmodule

// ### vcc_control_regs.sv
// Purpose: Control register bank of a low-power voice codec
// Assumes: Wishbone classic slave, 32-bit data, one clock
// Notes: Settings that shape the PCM stream apply at frame start
//
// Overview of operation
// R1: Clock select bits set divider ratio
// R2: Host picks clock before power-up command
// R3: Coding bit: linear low, companded high
// R4: Companded mode: law bits pick law
// R5: Linear mode: law bits pick number format
// R6: Frame format bit adds two-bit gap
// R7: Seven-bit option drops PCM LSB
// R8: Loopback returns received word on transmit
// R9: Timing bits pick delayed, normal, reversed
// R10: Latch pin is inverse of bit
// R11: Receive host access swaps decoder source
// R12: Transmit host access sends host word
// R13: Voice disable stops decode, floats transmit
// R14: Channel bit picks first or second slot
// R15: Host keeps supply bit low
// R16: Tone bits pick first, second, sum; with square waves the pair gives tone one gated by tone two
// R17: Waveform bit: square low, sine high
// R18: Tone frequency is code over range period
// R19: Reset bit clears all registers
// R20: Test bits enable two internal loops
// R21: Buzzer pin: PWM tone or static level
// R22: Duty is field times 1/128
// R23: Host never sets both range bits
// R24: Byte registers apply at frame boundary; the latch bit and the buzzer register act at once
//
// The Wishbone register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "vcc_defs.svh"
module vcc_control_regs (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Frame timing pin
    input wire logic frame_sync_pin,
    // PCM words from the serial datapath
    input wire vcc_pkg::vcc_byte_t rx_word,
    input wire vcc_pkg::vcc_byte_t enc_word,
    // Decoder side
    output vcc_pkg::vcc_byte_t dec_word,
    output logic dec_valid,
    // Transmit side
    output vcc_pkg::vcc_byte_t tx_word,
    output logic tx_valid,
    output logic tx_lsb_oe_n,
    output logic tx_oe_n,
    // Interface configuration
    output logic [2:0] mclk_div_ratio,
    output logic coding_companded,
    output logic [1:0] law_format,
    output logic [1:0] frame_gap_bits,
    output vcc_pkg::vcc_timing_t timing_mode,
    output logic slot_select,
    output logic loop_tx_to_rx,
    output logic loop_expander,
    // Tone, latch and buzzer
    output logic [8:0] tone_sample,
    output logic latch_output_pin,
    output logic buzzer_pin
);
    import vcc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Declarations
    ////////////////////////////////////////////////////////////////////
    vcc_byte_t reg_q [0:15];
    vcc_byte_t cfg0_q;
    vcc_byte_t cfg1_q;
    vcc_byte_t tone_ctl_q;
    vcc_byte_t tone1_q;
    vcc_byte_t tone2_q;
    vcc_byte_t range_q;
    logic sync1_q;
    logic sync2_q;
    logic sync3_q;
    logic frame_tick;
    logic ack_q;
    logic [31:0] rdat_q;
    logic take;
    logic wr_take;
    logic [3:0] idx;
    logic mapped;
    logic por_hit;
    logic cap_rx;
    vcc_byte_t rx_clean;
    vcc_byte_t dec_d;
    vcc_byte_t tx_d;
    logic voice_en;
    logic companded;
    logic seven_bit;
    logic loop_mode;
    logic rx_host;
    logic tx_host;
    logic [8:0] tone_d;
    logic [6:0] phase1_hi;
    logic sq2;
    vcc_range_t range_sel;
    vcc_timing_t timing_d;
    logic [2:0] div_d;

    function automatic logic is_mapped(input logic [3:0] i);
        return (i <= `VCC_IDX_BUZZER) || (i == `VCC_IDX_TEST_MUX);
    endfunction

    function automatic logic [2:0] div_ratio(input logic [1:0] sel);
        logic [2:0] r;
        r = `VCC_DIV_512K;
        case (sel)
            2'h0: r = `VCC_DIV_512K;
            2'h1: r = `VCC_DIV_1536K;
            2'h2: r = `VCC_DIV_2048K;
            default: r = `VCC_DIV_2560K;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Frame boundary from the sync pin
    ////////////////////////////////////////////////////////////////////
    // Pin is asynchronous: two stages before any edge logic
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end else begin
            sync1_q <= frame_sync_pin;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    assign frame_tick = sync2_q & ~sync3_q;

    ////////////////////////////////////////////////////////////////////
    // Wishbone decode
    ////////////////////////////////////////////////////////////////////
    assign take = wb_cyc_i & wb_stb_i & ~ack_q;
    assign idx = wb_adr_i[5:2];
    assign mapped = (wb_adr_i[7:6] == 2'b00) && is_mapped(idx);
    // Only the low byte lane carries register data
    assign wr_take = take & wb_we_i & wb_sel_i[0] & mapped;
    // R19 self-clearing reset bit
    assign por_hit = wr_take && (idx == `VCC_IDX_TEST_RANGE) &&
        wb_dat_i[`VCC_POR_BIT];

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= take;
            if (take && !wb_we_i) begin
                // Write-only word and holes read as zero
                rdat_q <= (mapped && idx != `VCC_IDX_TX_WORD) ?
                    {24'h000000, reg_q[idx]} : 32'h0000_0000;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    ////////////////////////////////////////////////////////////////////
    // Register file
    ////////////////////////////////////////////////////////////////////
    // R11 capture into receive word unless host owns it
    assign cap_rx = frame_tick & voice_en & ~rx_host;

    always_ff @(posedge clk_sys) begin
        if (reset || por_hit) begin
            for (int i = 0; i < 16; i++) begin
                reg_q[i] <= `VCC_RST_VALUE;
            end
        end else begin
            if (wr_take) begin
                reg_q[idx] <= wb_dat_i[7:0];
            end
            // Captured word wins over a same-cycle host write
            if (cap_rx) begin
                reg_q[`VCC_IDX_RX_WORD] <= rx_clean;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Frame-aligned working copies
    ////////////////////////////////////////////////////////////////////
    // R24 apply at frame start
    always_ff @(posedge clk_sys) begin
        if (reset || por_hit) begin
            cfg0_q <= `VCC_RST_VALUE;
            cfg1_q <= `VCC_RST_VALUE;
            tone_ctl_q <= `VCC_RST_VALUE;
            tone1_q <= `VCC_RST_VALUE;
            tone2_q <= `VCC_RST_VALUE;
            range_q <= `VCC_RST_VALUE;
        end else if (frame_tick) begin
            cfg0_q <= reg_q[`VCC_IDX_CLOCK_CODING];
            cfg1_q <= reg_q[`VCC_IDX_INTERFACE];
            tone_ctl_q <= reg_q[`VCC_IDX_TONE_CTRL];
            tone1_q <= reg_q[`VCC_IDX_TONE_ONE];
            tone2_q <= reg_q[`VCC_IDX_TONE_TWO];
            range_q <= reg_q[`VCC_IDX_TEST_RANGE];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Decoded mode bits
    ////////////////////////////////////////////////////////////////////
    // R13 voice enable
    assign voice_en = cfg1_q[`VCC_VOICE_EN];
    // R3 coding selection
    assign companded = cfg0_q[`VCC_CODING_BIT];
    // R7 only meaningful in companded mode
    assign seven_bit = cfg0_q[`VCC_SEVEN_BIT] & companded;
    assign loop_mode = cfg0_q[`VCC_DLOOP];
    assign rx_host = cfg1_q[`VCC_RX_HOST];
    assign tx_host = cfg1_q[`VCC_TX_HOST];
    // R7 received LSB ignored
    assign rx_clean = seven_bit ? {rx_word[7:1], 1'b0} : rx_word;

    // R9 timing selection
    assign timing_d = !cfg1_q[`VCC_TIM_DELAY] ? VCC_TIM_DELAYED :
        cfg1_q[`VCC_TIM_POL] ? VCC_TIM_REVERSED : VCC_TIM_NORMAL;
    // R1 divider ratio
    assign div_d = div_ratio({cfg0_q[`VCC_CLK_SEL_HI],
        cfg0_q[`VCC_CLK_SEL_LO]});
    // R18 a forbidden pair falls back to the standard range
    assign range_sel = vcc_range_t'({range_q[`VCC_RANGE_DBL],
        range_q[`VCC_RANGE_HALF]});

    ////////////////////////////////////////////////////////////////////
    // PCM word routing
    ////////////////////////////////////////////////////////////////////
    // R11 host word replaces serial input at the decoder
    assign dec_d = rx_host ? reg_q[`VCC_IDX_RX_WORD] : rx_clean;
    // R12 host word first, R8 loopback word next, encoder last
    assign tx_d = tx_host ? reg_q[`VCC_IDX_TX_WORD] :
        loop_mode ? reg_q[`VCC_IDX_RX_WORD] : enc_word;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            dec_word <= `VCC_RST_VALUE;
            dec_valid <= 1'b0;
            tx_word <= `VCC_RST_VALUE;
            tx_valid <= 1'b0;
        end else begin
            // R13 no decode while disabled; R8 none in loopback
            dec_valid <= frame_tick & voice_en & ~loop_mode;
            tx_valid <= frame_tick & voice_en;
            if (frame_tick) begin
                dec_word <= dec_d;
            end
            // R8 loopback word is the one captured this frame
            if (frame_tick && loop_mode && !tx_host) begin
                tx_word <= rx_clean;
            end else if (frame_tick) begin
                tx_word <= tx_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Configuration outputs
    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tx_oe_n <= 1'b1;
            tx_lsb_oe_n <= 1'b1;
            mclk_div_ratio <= `VCC_DIV_512K;
            coding_companded <= 1'b0;
            law_format <= 2'b00;
            frame_gap_bits <= 2'd0;
            timing_mode <= VCC_TIM_DELAYED;
            slot_select <= 1'b0;
            loop_tx_to_rx <= 1'b0;
            loop_expander <= 1'b0;
        end else begin
            // R13 transmit floats while voice is disabled
            tx_oe_n <= ~voice_en;
            // R7 transmit LSB left floating
            tx_lsb_oe_n <= ~voice_en | seven_bit;
            mclk_div_ratio <= div_d;
            coding_companded <= companded;
            // R4 law choice; R5 number format, same two bits
            law_format <= {cfg0_q[`VCC_LAW_HI], cfg0_q[`VCC_LAW_LO]};
            // R6 gap between the two slots
            frame_gap_bits <= cfg0_q[`VCC_FRAME_FMT] ?
                `VCC_GAP_BITS : 2'd0;
            timing_mode <= timing_d;
            // R14 bearer slot choice
            slot_select <= cfg1_q[`VCC_CHAN_SEL];
            // R20 internal test loops
            loop_tx_to_rx <= range_q[`VCC_TXRX_LOOP];
            loop_expander <= range_q[`VCC_EXP_LOOP];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Latch pin and tone output
    ////////////////////////////////////////////////////////////////////
    // Latch follows the written bit at once, frames or not
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            latch_output_pin <= 1'b1;
            tone_sample <= 9'h000;
        end else begin
            // R10 inverse of latch bit
            latch_output_pin <= ~reg_q[`VCC_IDX_INTERFACE][`VCC_LATCH];
            tone_sample <= tone_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Tone generator and buzzer
    ////////////////////////////////////////////////////////////////////
    vcc_tone_gen #(
        .ACC_W(32)
    ) u_tone (
        .clk_sys(clk_sys),
        .reset(reset),
        .tone1_on(tone_ctl_q[`VCC_TONE1_EN]),
        .tone2_on(tone_ctl_q[`VCC_TONE2_EN]),
        .sine_sel(tone_ctl_q[`VCC_WAVE_SEL]),
        .range_sel(range_sel),
        .freq1(tone1_q),
        .freq2(tone2_q),
        .sample(tone_d),
        .sq2(sq2),
        .phase1_hi(phase1_hi)
    );

    // Buzzer settings act at once so the pin works with frames stopped
    vcc_buzzer_pwm u_buzz (
        .clk_sys(clk_sys),
        .reset(reset),
        .buzz_en(reg_q[`VCC_IDX_BUZZER][`VCC_BUZ_EN]),
        .buzz_inv(reg_q[`VCC_IDX_BUZZER][`VCC_BUZ_INV]),
        .duty(reg_q[`VCC_IDX_BUZZER][`VCC_DUTY_HI:0]),
        .am_on(tone_ctl_q[`VCC_TONE2_EN]),
        .phase_hi(phase1_hi),
        .mod_level(sq2),
        .buzzer_pin(buzzer_pin)
    );
endmodule

// ### vcc_control_regs_props.sv
// Purpose: Port assertions for the codec control register bank
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to every instance of the bank
`timescale 1ns/10ps
module vcc_control_regs_props (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Stream and pins
    input wire logic dec_valid,
    input wire logic tx_valid,
    input wire logic tx_oe_n,
    input wire logic [2:0] mclk_div_ratio,
    input wire logic [1:0] frame_gap_bits,
    input wire vcc_pkg::vcc_timing_t timing_mode,
    input wire logic latch_output_pin,
    input wire logic buzzer_pin
);
    import vcc_pkg::*;
    ////////////////////////////////////////////////////////////////////
    wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic wr = req && wb_we_i && wb_sel_i[0];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_ack_single_pulse: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one cycle");
    a_ack_has_request: assert property ($rose(wb_ack_o) |-> $past(req))
        else $error("ack without request");
    a_read_upper_zero: assert property (wb_ack_o |->
        wb_dat_o[31:8] == 24'h0) else $error("read data upper bits set");
    a_divider_legal: assert property (mclk_div_ratio inside {1, 3, 4, 5})
        else $error("bad divider ratio");
    a_gap_legal: assert property (frame_gap_bits inside {0, 2})
        else $error("frame gap not 0 or 2");
    a_timing_onehot: assert property ($onehot(timing_mode))
        else $error("timing mode not one-hot");
    a_valid_pulse: assert property ((dec_valid || tx_valid) |=>
        !(dec_valid || tx_valid)) else $error("valid longer than a cycle");
    a_tx_enabled: assert property (tx_valid |-> !tx_oe_n)
        else $error("tx word while floated");
    a_latch_follows: assert property (wr && wb_adr_i == 8'h04 &&
        wb_dat_i[5] |-> ##[1:2] !latch_output_pin)
        else $error("latch pin not inverted");
    a_clear_pins: assert property (wr && wb_adr_i == 8'h28 &&
        wb_dat_i[7] |-> ##[1:2] (latch_output_pin && buzzer_pin))
        else $error("pins not reset by clear");
endmodule
bind vcc_control_regs vcc_control_regs_props u_vcc_control_regs_props (.*);

// ### vcc_frame_source.sv
// Purpose: Frame source standing in for the PCM serial side
// Assumes: One frame every 32 clocks, sync high for 8
// Notes: Words change just before the sync edge, stable all frame
`timescale 1ns/10ps
module vcc_frame_source (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Frame pin and PCM words
    output logic frame_sync_pin,
    output vcc_pkg::vcc_byte_t rx_word,
    output vcc_pkg::vcc_byte_t enc_word
);
    import vcc_pkg::*;
    logic [4:0] cnt_q;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cnt_q <= 5'h00;
            frame_sync_pin <= 1'b0;
            rx_word <= 8'h3C;
            enc_word <= 8'h96;
        end else begin
            cnt_q <= cnt_q + 5'h01;
            frame_sync_pin <= cnt_q < 5'h08;
            // New words each frame so a stuck capture shows up
            if (cnt_q == 5'h1F) begin
                rx_word <= rx_word + 8'h35;
                enc_word <= enc_word + 8'h4B;
            end
        end
    end
endmodule

// ### vcc_control_regs_test.sv
// Purpose: Self-checking bench for the codec control register bank
// Assumes: Frame source model drives the PCM side
// Notes: Bench acts as host; it keeps the supply and range bits legal
`timescale 1ns/10ps
module vcc_control_regs_test;
    import vcc_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic wb_ack_o, frame_sync_pin, dec_valid, tx_valid, tx_lsb_oe_n;
    logic tx_oe_n, coding_companded, slot_select, loop_tx_to_rx;
    logic loop_expander, latch_output_pin, buzzer_pin;
    vcc_byte_t rx_word, enc_word, dec_word, tx_word;
    vcc_timing_t timing_mode;
    logic [2:0] mclk_div_ratio;
    logic [1:0] law_format, frame_gap_bits;
    logic [8:0] tone_sample;
    int error_cnt = 0;
    int total_checks = 0;
    int cycles = 0;
    always #25 clk_sys = ~clk_sys;
    vcc_frame_source u_vcc_frame_source (.*);
    vcc_control_regs u_vcc_control_regs (.*);
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e,
            input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb(input logic w, input int idx, input logic [7:0] d);
        int n = 0;
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= {2'b00, idx[3:0], 2'b00};
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1);
        chk("ack", 2, n);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rdchk(input int idx, input logic [7:0] e);
        wb(1'b0, idx, 8'h00);
        chk("reg", {24'h0, e}, rd);
    endtask
    // Wait one frame past the next frame tick
    task automatic frm;
        repeat (2) @(posedge frame_sync_pin);
        repeat (6) @(posedge clk_sys);
    endtask
    task automatic wv;
        int n = 0;
        while (tx_valid !== 1'b1 && n < 100) begin
            @(posedge clk_sys);
            n++;
        end
        chk("tx_valid", 1, tx_valid);
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        chk("latch", 1, latch_output_pin);
        chk("tx_oe_n", 1, tx_oe_n);
        chk("timing", 1, timing_mode);
        for (int i = 0; i < 16; i++) begin
            rdchk(i, 8'h00);
            wb(1'b1, i, 8'h5A);
        end
        for (int i = 0; i < 16; i++)
            rdchk(i, (i inside {3, 12, 13, 15}) ? 8'h00 : 8'h5A);
        wb(1'b1, 10, 8'h80);
        for (int i = 0; i < 16; i++) rdchk(i, 8'h00);
        chk("buzzer", 1, buzzer_pin);
    endtask
    task automatic t_config;
        for (int c = 0; c < 4; c++) begin
            wb(1'b1, 0, {c[1:0], c[0], c[1], c[0], c[1], 2'b00});
            wb(1'b1, 1, {c[0] ^ c[1], c[1], c[1], 3'h0, c[0], 1'b0});
            wb(1'b1, 10, {4'h0, c[0], c[1], 2'b00});
            frm;
            chk("divider", c == 0 ? 1 : c + 2, mclk_div_ratio);
            chk("coding", c[0], coding_companded);
            chk("law", c[1:0], law_format);
            chk("gap", c[1] ? 2 : 0, frame_gap_bits);
            chk("timing", c == 1 ? 2 : c == 2 ? 4 : 1, timing_mode);
            chk("latch", !c[1], latch_output_pin);
            chk("slot", c[0], slot_select);
            chk("loop", {c[0], c[1]}, {loop_tx_to_rx, loop_expander});
        end
    endtask
    task automatic t_voice;
        wb(1'b1, 0, 8'h00);
        wb(1'b1, 3, 8'hA5);
        wb(1'b1, 1, 8'h0C);
        frm;
        wv;
        chk("host tx", 8'hA5, tx_word);
        chk("tx_oe_n", 0, tx_oe_n);
        chk("decode", {1'b1, rx_word}, {dec_valid, dec_word});
        rdchk(2, rx_word);
        wb(1'b1, 1, 8'h14);
        frm;
        wb(1'b1, 2, 8'h3C);
        frm;
        wv;
        chk("host rx", 8'h3C, dec_word);
        chk("encoder", enc_word, tx_word);
        wb(1'b1, 1, 8'h04);
        wb(1'b1, 0, 8'h23);
        frm;
        wv;
        chk("loop", {2'b00, rx_word[7:1]}, {dec_valid, tx_word[7:1]});
        chk("tx lsb", 0, tx_word[0]);
        chk("lsb_oe_n", 1, tx_lsb_oe_n);
        wb(1'b1, 1, 8'h00);
        frm;
        chk("tx_oe_n", 1, tx_oe_n);
    endtask
    task automatic t_buzz;
        int hi = 0, hs = 0;
        wb(1'b1, 11, 8'h40);
        repeat (2) @(posedge clk_sys);
        chk("buzzer", 0, buzzer_pin);
        wb(1'b1, 8, 8'hFF);
        wb(1'b1, 7, 8'h08);
        wb(1'b1, 11, 8'hE0);
        frm;
        // Window spans about two tone periods
        repeat (20000) begin
            @(posedge clk_sys);
            hi += buzzer_pin;
            hs += tone_sample == 9'h0FF;
        end
        chk("duty", 1, hi > 4800 && hi < 5200);
        chk("tone", 1, hs > 9800 && hs < 10200);
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            error_cnt++;
            print_verdict;
        end
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        t_regs;
        t_config;
        t_voice;
        t_buzz;
        print_verdict;
    end
endmodule
